// file: src/intc_map.svh
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH
// ********************************************************
// register byte offsets
// ********************************************************
`define SYSCTL_OFF   8'h00
`define PRIO_OFF     8'h04
`define SENSE_OFF    8'h08
`define CPUEN_OFF    8'h0C
`define XFEREN_OFF   8'h10
`define DMAEN_OFF    8'h14
`define SWVEC_OFF    8'h18
`define PEND_OFF     8'h1C
`define EVSTAT_OFF   8'h20
`define EVMASK_OFF   8'h24
`define ACCCFG_OFF   8'h28
`define ACCST_OFF    8'h2C
// ********************************************************
// reset values and field positions
// ********************************************************
`define SYSCTL_RST   3'h0
`define PRIO_RST     21'h000000
`define SENSE_RST    16'h0000
`define SWVEC_REQ    7
`define EV_NMI       0
`define EV_CPU       1
`define EV_XFER      2
`define EV_DMA       3
// ********************************************************
// vectors and fixed figures
// ********************************************************
`define NMI_VEC      8'h07
`define NMI_LEVEL    4'h8
`define IRQ0_VEC     8'h10
`define ADI_VEC      8'h1C
`define TMR_VECS     48'h3C_38_30_2C_28_20
`define RXI_VEC      8'h51
`define TXI_VEC      8'h52
`define XFER_BASE    16'h0400
`define HALT_STATE   4'hC
`define HALT_OPCODE  16'h57F3
`endif

// file: src/intc_pkg.sv
package intc_pkg;
  typedef enum logic [1:0] {
    MODE_FLAT = 2'h0,
    MODE_RSV1 = 2'h1,
    MODE_PRIO = 2'h2,
    MODE_RSV3 = 2'h3
  } ctrl_mode_type;

  typedef struct packed {
    logic       irq;
    logic [7:0] vec;
    logic [3:0] level;
  } cpu_req_type;

  typedef struct packed {
    logic        start;
    logic [15:0] vaddr;
  } xfer_req_type;
endpackage

// file: src/interrupt_and_transfer_dispatch.sv
`timescale 1ns/10ps
`include "intc_map.svh"
module interrupt_and_transfer_dispatch
  import intc_pkg::*;
#(
  parameter int NSRC = 17
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              nmi_pin,
  input  wire logic [7:0]        external_request_lines,
  input  wire logic              conversion_end_request,
  input  wire logic [5:0]        timer_compare_a_request,
  input  wire logic              serial_rx_full_request,
  input  wire logic              serial_tx_empty_request,
  input  wire logic              cpu_i_mask,
  input  wire logic [2:0]        cpu_mask_level,
  input  wire logic              cpu_nmi_inhibit,
  input  wire logic [3:0]        cpu_exec_state,
  input  wire logic [15:0]       cpu_opcode,
  input  wire logic              cpu_ack,
  output cpu_req_type            cpu_req,
  input  wire logic              xfer_busy,
  output xfer_req_type           xfer_req,
  output logic      [NSRC-1:0]   dma_start,
  output logic                   irq_out
);
  // ********************************************************
  // source tables
  // ********************************************************
  // sources: 0..7 lines, 8 conversion end, 9..14 timer A, 15 rx, 16 tx
  function automatic logic [7:0] src_vector(input int i);
    logic [47:0] t;
    t = `TMR_VECS;
    if (i < 8) return `IRQ0_VEC + 8'(i);
    if (i == 8) return `ADI_VEC;
    if (i < 15) return t[(i-9)*8 +: 8];
    if (i == 15) return `RXI_VEC;
    return `TXI_VEC;
  endfunction

  function automatic int src_module(input int i);
    if (i < 8) return i / 2;
    if (i == 8) return 4;
    if (i < 15) return 5;
    return 6;
  endfunction

  function automatic logic [15:0] xfer_addr(input logic [7:0] v);
    return `XFER_BASE + {7'h00, v, 1'b0};
  endfunction

  // internal=1; 8-bit bus 4 or 6+2m; 16-bit bus 2 or 3+m
  function automatic logic [7:0] acc_states(input logic [6:0] c);
    if (!c[0]) return 8'h01;
    if (c[1]) return c[2] ? 8'(4'h3 + c[6:3]) : 8'h02;
    return c[2] ? 8'(5'h06 + {c[6:3], 1'b0}) : 8'h04;
  endfunction

  // ********************************************************
  // registers
  // ********************************************************
  logic [2:0]      sysctl_q;
  logic [20:0]     prio_q;
  logic [15:0]     sense_q;
  logic [NSRC-1:0] cpuen_q, xferen_q, dmaen_q, pend_q, pend_d, prev_q, clr;
  logic [7:0]      swvec_q;
  logic [3:0]      evstat_q, evmask_q, ev_set;
  logic [6:0]      acccfg_q;
  logic [2:0]      nmi_sync_q;
  logic [7:0]      irq_s1_q, irq_s2_q;
  logic            nmi_pend_q, nmi_edge, nmi_take;
  logic [NSRC-1:0] lvl_in, evt;
  logic            wr_en, rd_setup, hit;
  logic [31:0]     rd_val;
  ctrl_mode_type   mode;
  logic [7:0]      xfer_vec_q;

  assign mode   = ctrl_mode_type'(sysctl_q[1:0]);
  assign wr_en  = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  // ********************************************************
  // apb slave
  // ********************************************************
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `SYSCTL_OFF: rd_val = {29'h0, sysctl_q};
      `PRIO_OFF:   rd_val = {11'h0, prio_q};
      `SENSE_OFF:  rd_val = {16'h0, sense_q};
      `CPUEN_OFF:  rd_val = 32'(cpuen_q);
      `XFEREN_OFF: rd_val = 32'(xferen_q);
      `DMAEN_OFF:  rd_val = 32'(dmaen_q);
      `SWVEC_OFF:  rd_val = {24'h0, swvec_q};
      `PEND_OFF:   rd_val = 32'(pend_q);
      `EVSTAT_OFF: rd_val = {28'h0, evstat_q};
      `EVMASK_OFF: rd_val = {28'h0, evmask_q};
      `ACCCFG_OFF: rd_val = {25'h0, acccfg_q};
      `ACCST_OFF:  rd_val = {24'h0, acc_states(acccfg_q)};
      default:     hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & ~hit;
      prdata  <= rd_setup ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysctl_q <= `SYSCTL_RST;
      prio_q   <= `PRIO_RST;
      sense_q  <= `SENSE_RST;
      cpuen_q  <= '0;
      xferen_q <= '0;
      dmaen_q  <= '0;
      evmask_q <= 4'h0;
      acccfg_q <= 7'h00;
    end else if (wr_en) begin
      unique case (paddr)
        `SYSCTL_OFF: sysctl_q <= pwdata[2:0];
        `PRIO_OFF:   prio_q   <= pwdata[20:0];
        `SENSE_OFF:  sense_q  <= pwdata[15:0];
        `CPUEN_OFF:  cpuen_q  <= pwdata[NSRC-1:0];
        `XFEREN_OFF: xferen_q <= pwdata[NSRC-1:0];
        `DMAEN_OFF:  dmaen_q  <= pwdata[NSRC-1:0];
        `EVMASK_OFF: evmask_q <= pwdata[3:0];
        `ACCCFG_OFF: acccfg_q <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // ********************************************************
  // input sensing
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle-high pins: reset to 1 so release makes no false edge
      nmi_sync_q <= 3'h7;
      irq_s1_q   <= 8'hFF;
      irq_s2_q   <= 8'hFF;
      prev_q     <= NSRC'(8'hFF);
    end else begin
      nmi_sync_q <= {nmi_sync_q[1:0], nmi_pin};
      irq_s1_q   <= external_request_lines;
      irq_s2_q   <= irq_s1_q;
      prev_q     <= lvl_in;
    end
  end

  assign lvl_in = {serial_tx_empty_request, serial_rx_full_request,
                   timer_compare_a_request, conversion_end_request, irq_s2_q};
  // sense 00 low level, 01 falling, 10 rising, 11 both
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      if (i < 8) begin
        unique case (sense_q[2*i +: 2])
          2'h0:    evt[i] = ~lvl_in[i];
          2'h1:    evt[i] = prev_q[i] & ~lvl_in[i];
          2'h2:    evt[i] = ~prev_q[i] & lvl_in[i];
          default: evt[i] = prev_q[i] ^ lvl_in[i];
        endcase
      end else begin
        evt[i] = lvl_in[i] & ~prev_q[i];
      end
    end
  end
  // sysctl bit 2 set selects rising edge
  assign nmi_edge = sysctl_q[2] ? (nmi_sync_q[1] & ~nmi_sync_q[2])
                                : (~nmi_sync_q[1] & nmi_sync_q[2]);

  // ********************************************************
  // cpu arbitration
  // ********************************************************
  logic       cpu_any;
  logic [2:0] best_lvl;
  int         best;
  always_comb begin
    cpu_any  = 1'b0;
    best_lvl = 3'h0;
    best     = 0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      // lowest index wins a tie; transfer-enabled sources go elsewhere
      if (pend_q[i] & cpuen_q[i] & ~xferen_q[i]) begin
        if (mode == MODE_PRIO) begin
          if (prio_q[3*src_module(i) +: 3] > cpu_mask_level &&
              (!cpu_any || prio_q[3*src_module(i) +: 3] >= best_lvl)) begin
            cpu_any  = 1'b1;
            best_lvl = prio_q[3*src_module(i) +: 3];
            best     = i;
          end
        end else if (!cpu_i_mask) begin
          cpu_any = 1'b1;
          best    = i;
        end
      end
    end
  end

  // nmi nests over anything; opcode 57F3 in state 12 lifts the inhibit
  assign nmi_take = nmi_pend_q & (~cpu_nmi_inhibit |
                    (cpu_exec_state == `HALT_STATE && cpu_opcode == `HALT_OPCODE));

  logic [NSRC-1:0] cpu_src_q;
  logic            cpu_nmi_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_req   <= '0;
      cpu_src_q <= '0;
      cpu_nmi_q <= 1'b0;
    end else if (nmi_take) begin
      cpu_req   <= '{irq: 1'b1, vec: `NMI_VEC, level: `NMI_LEVEL};
      cpu_src_q <= '0;
      cpu_nmi_q <= 1'b1;
    end else begin
      cpu_req   <= '{irq: cpu_any, vec: src_vector(best), level: {1'b0, best_lvl}};
      cpu_src_q <= cpu_any ? NSRC'(1) << best : '0;
      cpu_nmi_q <= 1'b0;
    end
  end

  // ********************************************************
  // transfer controller start, fixed order
  // ********************************************************
  logic       x_any;
  logic [7:0] x_vec;
  int         x_idx;
  always_comb begin
    x_any = swvec_q[`SWVEC_REQ];
    x_vec = {1'b0, swvec_q[6:0]};
    x_idx = NSRC;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (!swvec_q[`SWVEC_REQ] && pend_q[i] && xferen_q[i]) begin
        x_any = 1'b1;
        x_vec = src_vector(i);
        x_idx = i;
      end
    end
  end

  logic x_go;
  assign x_go = x_any & ~xfer_busy & ~xfer_req.start;

  // the engine itself fetches, moves and writes back its register set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_req   <= '0;
      xfer_vec_q <= 8'h00;
    end else begin
      xfer_req.start <= x_go;
      if (x_go) begin
        xfer_req.vaddr <= xfer_addr(x_vec);
        xfer_vec_q     <= x_vec;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swvec_q <= 8'h00;
    end else if (wr_en && paddr == `SWVEC_OFF) begin
      swvec_q <= pwdata[7:0];
    end else if (x_go && swvec_q[`SWVEC_REQ]) begin
      swvec_q[`SWVEC_REQ] <= 1'b0;
    end
  end

  // ********************************************************
  // pending flags and dma; a new event wins over its clear
  // ********************************************************
  always_comb begin
    clr = cpu_ack ? cpu_src_q : '0;
    if (x_go && x_idx < NSRC) clr[x_idx] = 1'b1;
    pend_d = (pend_q & ~clr) | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q     <= '0;
      nmi_pend_q <= 1'b0;
      dma_start  <= '0;
    end else begin
      pend_q     <= pend_d;
      nmi_pend_q <= nmi_edge | (nmi_pend_q & ~(cpu_ack & cpu_nmi_q));
      dma_start  <= evt & dmaen_q;
    end
  end

  // ********************************************************
  // event status and interrupt output
  // ********************************************************
  assign ev_set = {|dma_start, xfer_req.start, cpu_ack, nmi_edge};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evstat_q <= 4'h0;
      irq_out  <= 1'b0;
    end else begin
      evstat_q <= (evstat_q & ~((wr_en && paddr == `EVSTAT_OFF) ? pwdata[3:0] : 4'h0))
                  | ev_set;
      irq_out  <= |(evstat_q & evmask_q);
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  a_nmi_level: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_req.irq && cpu_nmi_q |-> cpu_req.level == `NMI_LEVEL && cpu_req.vec == `NMI_VEC)
    else $error("nmi not at level 8");
  a_nmi_catch: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_edge |=> nmi_pend_q)
    else $error("nmi edge lost");
  a_xfer_addr: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_req.start |-> xfer_req.vaddr == `XFER_BASE + {7'h00, xfer_vec_q, 1'b0})
    else $error("bad transfer vector address");
  a_adi_addr: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_req.start && xfer_vec_q == `ADI_VEC |-> xfer_req.vaddr == 16'h0438)
    else $error("conversion end address wrong");
  a_sw_first: assert property (@(posedge pclk) disable iff (!presetn)
    swvec_q[`SWVEC_REQ] && !xfer_busy && !xfer_req.start && !wr_en
    |=> xfer_req.start && xfer_vec_q == {1'b0, $past(swvec_q[6:0])})
    else $error("software transfer not first");
  a_prio_mask: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_req.irq && !cpu_nmi_q && $past(mode) == MODE_PRIO
    |-> cpu_req.level > {1'b0, $past(cpu_mask_level)})
    else $error("level not above mask");
  a_flat_mask: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mode) == MODE_FLAT && $past(cpu_i_mask) && !cpu_nmi_q |-> !cpu_req.irq)
    else $error("masked request reached cpu");
  a_steal_cpu: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_req.irq && !cpu_nmi_q |-> ($past(xferen_q) & cpu_src_q) == '0)
    else $error("transfer source sent to cpu");
  a_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr > `ACCST_OFF |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_irq_out: assert property (@(posedge pclk) disable iff (!presetn)
    irq_out == $past(|(evstat_q & evmask_q)))
    else $error("interrupt output mismatch");
endmodule

// file: testbench/intc_partner_model.sv
`timescale 1ns/10ps
// ********************************************************
// core and transfer engine stand-in
// ********************************************************
module intc_partner_model
  import intc_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire cpu_req_type  cpu_req,
  input  wire xfer_req_type xfer_req,
  input  wire logic [7:0]   ack_delay,
  input  wire logic [7:0]   busy_len,
  output logic              cpu_ack,
  output logic              xfer_busy
);
  logic [7:0] wait_q;
  logic [7:0] busy_q;
  logic [2:0] hold_q;

  // hold-off keeps a second ack away until the cleared source drops irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q  <= 8'h00;
      hold_q  <= 3'h0;
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end else if (cpu_req.irq) begin
        if (wait_q >= ack_delay) begin
          cpu_ack <= 1'b1;
          wait_q  <= 8'h00;
          hold_q  <= 3'h4;
        end else begin
          wait_q <= wait_q + 8'h01;
        end
      end else begin
        wait_q <= 8'h00;
      end
    end
  end

  // busy covers load, transfer and write-back of the register set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q    <= 8'h00;
      xfer_busy <= 1'b0;
    end else if (xfer_req.start) begin
      busy_q    <= busy_len;
      xfer_busy <= 1'b1;
    end else if (busy_q > 8'h01) begin
      busy_q <= busy_q - 8'h01;
    end else begin
      busy_q    <= 8'h00;
      xfer_busy <= 1'b0;
    end
  end
endmodule

// file: testbench/interrupt_and_transfer_dispatch_test.sv
`timescale 1ns/10ps
`include "intc_map.svh"
module interrupt_and_transfer_dispatch_test;
  import intc_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, nmi, err;
  logic         conv, rxf, txe, imask, inh, ack, busy, irq;
  logic [2:0]   mlvl;
  logic [3:0]   est;
  logic [5:0]   tmr;
  logic [7:0]   paddr, ext, ack_dly, busy_n;
  logic [15:0]  opc;
  logic [16:0]  dma, dma_seen;
  logic [31:0]  pwdata, prdata, rd;
  cpu_req_type  creq;
  xfer_req_type xreq;
  logic [11:0]  cq[$];
  logic [15:0]  xq[$];
  int           n_errors, samples_checked;
  localparam logic [7:0] acc_cfg [5] = '{8'h00, 8'h01, 8'h15, 8'h03, 8'h17};
  localparam logic [7:0] acc_exp [5] = '{8'h01, 8'h04, 8'h0A, 8'h02, 8'h05};

  interrupt_and_transfer_dispatch i_interrupt_and_transfer_dispatch (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_pin(nmi), .external_request_lines(ext), .conversion_end_request(conv),
    .timer_compare_a_request(tmr), .serial_rx_full_request(rxf),
    .serial_tx_empty_request(txe), .cpu_i_mask(imask), .cpu_mask_level(mlvl),
    .cpu_nmi_inhibit(inh), .cpu_exec_state(est), .cpu_opcode(opc), .cpu_ack(ack),
    .cpu_req(creq), .xfer_busy(busy), .xfer_req(xreq), .dma_start(dma), .irq_out(irq));
  intc_partner_model i_intc_partner_model (.pclk(pclk), .presetn(presetn),
    .cpu_req(creq), .xfer_req(xreq), .ack_delay(ack_dly), .busy_len(busy_n),
    .cpu_ack(ack), .xfer_busy(busy));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ********************************************************
  // monitors and shared tasks
  // ********************************************************
  always @(posedge pclk) begin
    if (ack === 1'b1) cq.push_back({creq.vec, creq.level});
    if (xreq.start === 1'b1) xq.push_back(xreq.vaddr);
    dma_seen <= presetn ? (dma_seen | dma) : '0;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test();
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check_word(rd, e);
  endtask

  task automatic wait_q(input int nc, input int nx);
    int n;
    n = 0;
    while ((cq.size() < nc || xq.size() < nx) && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) hang();
  endtask

  task automatic conv_pulse();
    @(posedge pclk);
    conv <= 1'b1;
    repeat (2) @(posedge pclk);
    conv <= 1'b0;
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    {psel, penable, pwrite, conv, rxf, txe, imask, inh, presetn} = '0;
    {paddr, pwdata, mlvl, est, tmr, opc} = '0;
    nmi = 1'b1;
    ext = 8'hFF;
    ack_dly = 8'h00;
    busy_n = 8'h02;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`SYSCTL_OFF, 32'h0);
    rdchk(`SENSE_OFF, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check_word({31'h0, err}, 32'h1);
    wr(`PRIO_OFF, 32'hFFFFFFFF);
    rdchk(`PRIO_OFF, 32'h001FFFFF);
    wr(`PRIO_OFF, 32'h00005000);
    wr(`CPUEN_OFF, 32'h100);
    ack_dly <= 8'h05;
    conv_pulse();
    wait_q(1, 0);
    check_word({24'h0, cq[0][11:4]}, 32'h1C);
    check_word({31'h0, irq}, 32'h0);
    wr(`EVMASK_OFF, 32'h2);
    repeat (2) @(posedge pclk);
    check_word({31'h0, irq}, 32'h1);
    wr(`EVSTAT_OFF, 32'h2);
    repeat (2) @(posedge pclk);
    check_word({31'h0, irq}, 32'h0);
    // level 5 against mask 5 must wait until the mask drops
    ack_dly <= 8'h00;
    wr(`SYSCTL_OFF, 32'h2);
    mlvl <= 3'h5;
    conv_pulse();
    repeat (20) @(posedge pclk);
    check_word(cq.size(), 1);
    mlvl <= 3'h4;
    wait_q(2, 0);
    check_word({20'h0, cq[1]}, {20'h0, 8'h1C, 4'h5});
    wr(`SYSCTL_OFF, 32'h6);
    imask <= 1'b1;
    mlvl <= 3'h7;
    inh <= 1'b1;
    nmi <= 1'b0;
    repeat (20) @(posedge pclk);
    check_word(cq.size(), 2);
    nmi <= 1'b1;
    repeat (20) @(posedge pclk);
    check_word(cq.size(), 2);
    est <= 4'hC;
    opc <= 16'h57F3;
    wait_q(3, 0);
    check_word({20'h0, cq[2]}, {20'h0, 8'h07, 4'h8});
    {imask, inh, mlvl, est} <= '0;
    wr(`SYSCTL_OFF, 32'h0);
    wr(`SENSE_OFF, 32'h1);
    wr(`CPUEN_OFF, 32'h1);
    wr(`DMAEN_OFF, 32'h10001);
    ext <= 8'hFE;
    txe <= 1'b1;
    wait_q(4, 0);
    check_word({24'h0, cq[3][11:4]}, 32'h10);
    check_word({15'h0, dma_seen}, 32'h00010001);
    ext <= 8'hFF;
    txe <= 1'b0;
    wr(`XFEREN_OFF, 32'h100);
    wr(`CPUEN_OFF, 32'h100);
    conv_pulse();
    wait_q(4, 1);
    repeat (10) @(posedge pclk);
    check_word({16'h0, xq[0]}, 32'h0438);
    check_word(cq.size(), 4);
    // long busy lets the software and timer requests pile up together
    busy_n <= 8'h28;
    wr(`XFEREN_OFF, 32'h300);
    conv_pulse();
    wait_q(4, 2);
    tmr <= 6'h01;
    wr(`SWVEC_OFF, 32'h85);
    tmr <= 6'h00;
    wait_q(4, 4);
    check_word({16'h0, xq[2]}, 32'h040A);
    check_word({16'h0, xq[3]}, 32'h0440);
    rdchk(`SWVEC_OFF, 32'h05);
    for (int i = 0; i < 5; i++) begin
      wr(`ACCCFG_OFF, {24'h0, acc_cfg[i]});
      rdchk(`ACCST_OFF, {24'h0, acc_exp[i]});
    end
    stop_test();
  end
endmodule
